//--- rtl/uie_in_ep_ctrl.sv
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
// How it works
// - writing clear-toggle zeroes the endpoint toggle; the bit reads back zero
// - stall sent: set stall-sent, flush FIFO, drop packet-ready, raise interrupt request
// - send-stall set: every IN token gets STALL until firmware clears it
// - send-stall is ignored on isochronous endpoints
// - flush discards the next queued packet, drops packet-ready, self-clears
// - isochronous IN with nothing loaded: underrun set, zero-length packet sent
// - bulk/interrupt NAK sets underrun; firmware clears it
// - packet-present reads one exactly while a packet is queued
// - packet sent: packet-ready cleared, interrupt requested
// - auto-set marks a packet ready once max-size bytes are loaded
// - type bit: zero bulk/interrupt, one isochronous
// - force-toggle switches toggle and drops the packet even without ACK
// - double-buffer bit allows two queued packets
// - OUT max packet size, in 8-byte units, held per selected endpoint
// - index zero shows the endpoint 0 register at the IN low address
module uie_in_ep_ctrl (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [uie_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                awprot,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  input  wire logic [uie_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]                arprot,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  input  wire logic                      in_token,
  input  wire logic [2:0]                token_ep,
  output uie_pkg::uie_reply_t            reply,
  output logic                           reply_toggle,
  input  wire logic                      tx_done,
  input  wire logic [2:0]                tx_ep,
  input  wire logic                      tx_acked,
  input  wire logic                      byte_loaded,
  input  wire logic [2:0]                load_ep,
  output logic                           fifo_discard,
  output logic [2:0]                     fifo_discard_ep,
  output logic                           fifo_discard_all,
  output logic [2:0]                     fifo_discard_all_ep,
  output logic [5:1]                     ep_irq,
  input  wire logic [7:0]                ep0_status,
  output logic                           ep0_write,
  output logic [7:0]                     ep0_wdata
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [3:0]  index, next_index;
  logic [5:1]  toggle, sent_stall, send_stall, underrun, auto_mark_loaded, iso, force_tog, dbl;
  logic [5:1]  next_toggle, next_sent_stall, next_send_stall, next_underrun;
  logic [5:1]  next_auto, next_iso, next_force, next_dbl;
  logic [1:0]  rsv [1:5];
  logic [1:0]  next_rsv [1:5];
  logic [1:0]  cnt [1:5];
  logic [1:0]  next_cnt [1:5];
  logic [10:0] bytes [1:5];
  logic [10:0] next_bytes [1:5];
  logic [7:0]  maxi [1:5];
  logic [7:0]  next_maxi [1:5];
  logic [7:0]  maxo [1:5];
  logic [7:0]  next_maxo [1:5];
  logic        next_discard, next_discard_all;
  logic [2:0]  next_discard_ep, next_discard_all_ep;
  logic [5:1]  next_irq;
  logic        next_ep0_write;
  logic [7:0]  next_ep0_wdata;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic [15:0] aw_idx, ar_idx;
  logic        wr_take, rd_take, wr_mapped, wr_en, ep_ok, rd_ok;
  logic        wr_low, wr_high, wr_maxi, wr_maxo;
  logic [7:0]  wr_byte, rd_byte;
  logic [2:0]  ei;

  assign aw_idx    = awaddr[uie_pkg::ADDR_W-1:2];
  assign ar_idx    = araddr[uie_pkg::ADDR_W-1:2];
  // address and data are taken together; a master offering one waits for the other
  assign wr_take   = awvalid && wvalid && !bvalid;
  assign awready   = wr_take;
  assign wready    = wr_take;
  assign rd_take   = arvalid && !rvalid;
  assign arready   = !rvalid;
  assign wr_byte   = wdata[7:0];
  assign wr_low    = aw_idx == uie_pkg::IDX_IN_CS_LO;
  assign wr_high   = aw_idx == uie_pkg::IDX_IN_CS_HI;
  assign wr_maxi   = aw_idx == uie_pkg::IDX_IN_MAX;
  assign wr_maxo   = aw_idx == uie_pkg::IDX_OUT_MAX;
  assign wr_mapped = wr_low || wr_high || wr_maxi || wr_maxo || aw_idx == uie_pkg::IDX_EP_SELECT;
  assign wr_en     = wr_take && wr_mapped && wstrb[0];
  assign ep_ok     = index != 4'h0 && index <= uie_pkg::NUM_EP;
  assign ei        = ep_ok ? index[2:0] : 3'h1;

  always_comb begin
    rd_ok   = 1'b1;
    rd_byte = 8'h00;
    if (ar_idx == uie_pkg::IDX_EP_SELECT) begin
      rd_byte = {4'h0, index};
    end else if (ar_idx == uie_pkg::IDX_IN_MAX) begin
      rd_byte = ep_ok ? maxi[ei] : 8'h00;
    end else if (ar_idx == uie_pkg::IDX_IN_CS_LO) begin
      if (index == 4'h0) begin
        rd_byte = ep0_status;
      end else if (ep_ok) begin
        rd_byte = {2'h0, sent_stall[ei], send_stall[ei], 1'b0, underrun[ei],
                   cnt[ei] != 2'h0, cnt[ei] == (dbl[ei] ? 2'h2 : 2'h1)};
      end
    end else if (ar_idx == uie_pkg::IDX_IN_CS_HI) begin
      if (ep_ok) begin
        rd_byte = {auto_mark_loaded[ei], iso[ei], rsv[ei], force_tog[ei], 2'h0, dbl[ei]};
      end
    end else if (ar_idx == uie_pkg::IDX_OUT_MAX) begin
      rd_byte = ep_ok ? maxo[ei] : 8'h00;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // bus answer
  // ---------------------------------------------------------------
  always_comb begin
    next_bvalid = bvalid;
    next_bresp  = bresp;
    next_rvalid = rvalid;
    next_rresp  = rresp;
    next_rdata  = rdata;
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_take) begin
      next_bvalid = 1'b1;
      next_bresp  = wr_mapped ? uie_pkg::RESP_OKAY : uie_pkg::RESP_DECERR;
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (rd_take) begin
      next_rvalid = 1'b1;
      next_rresp  = rd_ok ? uie_pkg::RESP_OKAY : uie_pkg::RESP_DECERR;
      next_rdata  = {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= uie_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rresp  <= uie_pkg::RESP_OKAY;
      rdata  <= 32'h00000000;
    end else begin
      bvalid <= next_bvalid;
      bresp  <= next_bresp;
      rvalid <= next_rvalid;
      rresp  <= next_rresp;
      rdata  <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // token answer
  // ---------------------------------------------------------------
  always_comb begin
    reply        = uie_pkg::UIE_NAK;
    reply_toggle = 1'b0;
    for (int e = 1; e <= 5; e++) begin
      if (token_ep == 3'(e)) begin
        reply_toggle = toggle[e];
        if (send_stall[e] && !iso[e]) begin
          reply = uie_pkg::UIE_STALL;
        end else if (cnt[e] != 2'h0) begin
          reply = uie_pkg::UIE_DATA;
        end else if (iso[e]) begin
          reply = uie_pkg::UIE_ZLP;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // endpoint state
  // ---------------------------------------------------------------
  always_comb begin
    next_index          = index;
    next_toggle         = toggle;
    next_sent_stall     = sent_stall;
    next_send_stall     = send_stall;
    next_underrun       = underrun;
    next_auto           = auto_mark_loaded;
    next_iso            = iso;
    next_force          = force_tog;
    next_dbl            = dbl;
    next_rsv            = rsv;
    next_cnt            = cnt;
    next_bytes          = bytes;
    next_maxi           = maxi;
    next_maxo           = maxo;
    next_discard        = 1'b0;
    next_discard_ep     = 3'h0;
    next_discard_all    = 1'b0;
    next_discard_all_ep = 3'h0;
    next_irq            = 5'h00;
    next_ep0_write      = wr_en && wr_low && index == 4'h0;
    next_ep0_wdata      = next_ep0_write ? wr_byte : ep0_wdata;
    if (wr_en && aw_idx == uie_pkg::IDX_EP_SELECT) begin
      next_index = wr_byte[3:0];
    end
    for (int e = 1; e <= 5; e++) begin
      // software first, so that a hardware event in the same cycle wins; clear-toggle alone is applied after the hardware events
      if (wr_en && index == 4'(e)) begin
        if (wr_low) begin
          next_sent_stall[e] = wr_byte[uie_pkg::LO_SENT_STALL];
          next_send_stall[e] = wr_byte[uie_pkg::LO_SEND_STALL];
          next_underrun[e]   = wr_byte[uie_pkg::LO_UNDERRUN];
          if (wr_byte[uie_pkg::LO_LOADED] && cnt[e] != (dbl[e] ? 2'h2 : 2'h1)) begin
            next_cnt[e]   = cnt[e] + 2'h1;
            next_bytes[e] = 11'h000;
          end
          if (wr_byte[uie_pkg::LO_FLUSH] && cnt[e] != 2'h0) begin
            next_cnt[e]     = next_cnt[e] - 2'h1;
            next_discard    = 1'b1;
            next_discard_ep = 3'(e);
          end
        end
        if (wr_high) begin
          next_auto[e]  = wr_byte[uie_pkg::HI_AUTO];
          next_iso[e]   = wr_byte[uie_pkg::HI_ISO];
          next_rsv[e]   = wr_byte[uie_pkg::HI_RSV +: 2];
          next_force[e] = wr_byte[uie_pkg::HI_FORCE];
          next_dbl[e]   = wr_byte[uie_pkg::HI_DBL];
        end
        if (wr_maxi) begin
          next_maxi[e] = wr_byte;
        end
        if (wr_maxo) begin
          next_maxo[e] = wr_byte;
        end
      end
      if (byte_loaded && load_ep == 3'(e)) begin
        next_bytes[e] = bytes[e] + 11'h001;
        // a limit of zero never fires, so an unprogrammed endpoint is not committed
        if (auto_mark_loaded[e] && maxi[e] != 8'h00 && next_bytes[e] == {maxi[e], 3'h0}
            && next_cnt[e] != (dbl[e] ? 2'h2 : 2'h1)) begin
          next_cnt[e]   = next_cnt[e] + 2'h1;
          next_bytes[e] = 11'h000;
        end
      end
      if (tx_done && tx_ep == 3'(e)) begin
        if ((iso[e] || tx_acked || force_tog[e]) && cnt[e] != 2'h0) begin
          // a flush in the same cycle may already have taken the packet; never wrap the count
          if (next_cnt[e] != 2'h0) begin
            next_cnt[e] = next_cnt[e] - 2'h1;
          end
          next_irq[e] = 1'b1;
        end
        if (force_tog[e] && !tx_acked) begin
          next_discard    = 1'b1;
          next_discard_ep = 3'(e);
        end
        if ((!iso[e] && tx_acked) || force_tog[e]) begin
          next_toggle[e] = !toggle[e];
        end
      end
      if (in_token && token_ep == 3'(e)) begin
        if (reply == uie_pkg::UIE_STALL) begin
          next_sent_stall[e]  = 1'b1;
          next_cnt[e]         = 2'h0;
          next_bytes[e]       = 11'h000;
          next_discard_all    = 1'b1;
          next_discard_all_ep = 3'(e);
          next_irq[e]         = 1'b1;
        end else if (reply != uie_pkg::UIE_DATA) begin
          next_underrun[e] = 1'b1;
        end
      end
      if (wr_en && index == 4'(e) && wr_low && wr_byte[uie_pkg::LO_CLR_TOG]) begin
        next_toggle[e] = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      index               <= uie_pkg::RST_INDEX;
      toggle              <= 5'h00;
      sent_stall          <= 5'h00;
      send_stall          <= 5'h00;
      underrun            <= 5'h00;
      auto_mark_loaded    <= 5'h00;
      iso                 <= 5'h00;
      force_tog           <= 5'h00;
      dbl                 <= 5'h00;
      for (int e = 1; e <= 5; e++) begin
        rsv[e]   <= uie_pkg::RST_RSV;
        cnt[e]   <= 2'h0;
        bytes[e] <= 11'h000;
        maxi[e]  <= uie_pkg::RST_MAX;
        maxo[e]  <= uie_pkg::RST_MAX;
      end
      fifo_discard        <= 1'b0;
      fifo_discard_ep     <= 3'h0;
      fifo_discard_all    <= 1'b0;
      fifo_discard_all_ep <= 3'h0;
      ep_irq              <= 5'h00;
      ep0_write           <= 1'b0;
      ep0_wdata           <= 8'h00;
    end else begin
      index               <= next_index;
      toggle              <= next_toggle;
      sent_stall          <= next_sent_stall;
      send_stall          <= next_send_stall;
      underrun            <= next_underrun;
      auto_mark_loaded    <= next_auto;
      iso                 <= next_iso;
      force_tog           <= next_force;
      dbl                 <= next_dbl;
      rsv                 <= next_rsv;
      cnt                 <= next_cnt;
      bytes               <= next_bytes;
      maxi                <= next_maxi;
      maxo                <= next_maxo;
      fifo_discard        <= next_discard;
      fifo_discard_ep     <= next_discard_ep;
      fifo_discard_all    <= next_discard_all;
      fifo_discard_all_ep <= next_discard_all_ep;
      ep_irq              <= next_irq;
      ep0_write           <= next_ep0_write;
      ep0_wdata           <= next_ep0_wdata;
    end
  end

  // ---------------------------------------------------------------
  // checks on endpoint 1 and the endpoint 0 view
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic wr1, tok1, stall1;
  assign wr1    = wr_en && index == 4'h1;
  assign tok1   = in_token && token_ep == 3'h1;
  assign stall1 = tok1 && send_stall[1] && !iso[1];

  property p_clr_tog;
    wr1 && wr_low && wr_byte[uie_pkg::LO_CLR_TOG] |=> !toggle[1];
  endproperty
  a_clr_tog: assert property (p_clr_tog) else $error("toggle not cleared");
  property p_stall_flush;
    stall1 |=> sent_stall[1] && cnt[1] == 2'h0 && fifo_discard_all && ep_irq[1];
  endproperty
  a_stall_flush: assert property (p_stall_flush) else $error("stall did not flush");
  property p_stall_reply;
    stall1 |-> reply == uie_pkg::UIE_STALL;
  endproperty
  a_stall_reply: assert property (p_stall_reply) else $error("stall not answered");
  property p_iso_no_stall;
    tok1 && iso[1] |-> reply != uie_pkg::UIE_STALL;
  endproperty
  a_iso_no_stall: assert property (p_iso_no_stall) else $error("iso endpoint stalled");
  property p_flush;
    wr1 && wr_low && wr_byte[uie_pkg::LO_FLUSH] && cnt[1] != 2'h0 && !tx_done |=> fifo_discard && fifo_discard_ep == 3'h1;
  endproperty
  a_flush: assert property (p_flush) else $error("flush not issued");
  property p_iso_under;
    tok1 && iso[1] && cnt[1] == 2'h0 |-> reply == uie_pkg::UIE_ZLP ##1 underrun[1];
  endproperty
  a_iso_under: assert property (p_iso_under) else $error("iso underrun missed");
  property p_nak_under;
    tok1 && reply == uie_pkg::UIE_NAK |=> underrun[1];
  endproperty
  a_nak_under: assert property (p_nak_under) else $error("nak underrun missed");
  property p_present;
    rd_take && ar_idx == uie_pkg::IDX_IN_CS_LO && index == 4'h1 |=> rdata[1] == ($past(cnt[1]) != 2'h0);
  endproperty
  a_present: assert property (p_present) else $error("present flag wrong");
  property p_sent_irq;
    tx_done && tx_ep == 3'h1 && tx_acked && cnt[1] != 2'h0 |=> ep_irq[1] ##1 !ep_irq[1];
  endproperty
  a_sent_irq: assert property (p_sent_irq) else $error("sent packet not reported");
  property p_toggle;
    tx_done && tx_ep == 3'h1 && tx_acked && !iso[1] && !wr1 |=> toggle[1] != $past(toggle[1]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not flip");
  property p_ep0;
    rd_take && ar_idx == uie_pkg::IDX_IN_CS_LO && index == 4'h0 |=> rdata[7:0] == $past(ep0_status);
  endproperty
  a_ep0: assert property (p_ep0) else $error("endpoint 0 view wrong");
  c_stall: cover property (stall1 ##1 fifo_discard_all);
  c_auto: cover property (byte_loaded && load_ep == 3'h1 && auto_mark_loaded[1] ##1 cnt[1] != 2'h0);
  c_double: cover property (cnt[1] == 2'h2);
endmodule

//--- rtl/uie_pkg.sv
package uie_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_EP_SELECT = 16'hde0e;
  localparam logic [15:0] IDX_IN_MAX    = 16'hde10;
  localparam logic [15:0] IDX_IN_CS_LO  = 16'hde11;
  localparam logic [15:0] IDX_IN_CS_HI  = 16'hde12;
  localparam logic [15:0] IDX_OUT_MAX   = 16'hde13;
  localparam int          ADDR_W        = 18;
  localparam logic [3:0]  NUM_EP        = 4'h5;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [3:0]  RST_INDEX     = 4'h0;
  localparam logic [7:0]  RST_MAX       = 8'h00;
  localparam logic [1:0]  RST_RSV       = 2'h2;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LO_CLR_TOG    = 6;
  localparam int LO_SENT_STALL = 5;
  localparam int LO_SEND_STALL = 4;
  localparam int LO_FLUSH      = 3;
  localparam int LO_UNDERRUN   = 2;
  localparam int LO_PRESENT    = 1;
  localparam int LO_LOADED     = 0;
  localparam int HI_AUTO       = 7;
  localparam int HI_ISO        = 6;
  localparam int HI_RSV        = 4;
  localparam int HI_FORCE      = 3;
  localparam int HI_DBL        = 0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {UIE_NAK, UIE_STALL, UIE_DATA, UIE_ZLP} uie_reply_t;
endpackage

//--- verification/uie_host_model.sv
`timescale 1ns/10ps
module uie_host_model (
  input  wire logic                aclk,
  input  wire uie_pkg::uie_reply_t reply,
  input  wire logic                reply_toggle,
  output logic                     in_token,
  output logic [2:0]               token_ep,
  output logic                     tx_done,
  output logic [2:0]               tx_ep,
  output logic                     tx_acked
);
  // ------
  // host strobes
  // ------
  initial begin
    {in_token, token_ep, tx_done, tx_ep, tx_acked} = '0;
  end
  // idle qualifiers are inverted so the idle value never matches the endpoint just used
  task automatic tok(input logic [2:0] ep, output uie_pkg::uie_reply_t r, output logic t);
    @(posedge aclk);
    in_token <= 1'b1;
    token_ep <= ep;
    @(negedge aclk);
    r = reply;
    t = reply_toggle;
    @(posedge aclk);
    in_token <= 1'b0;
    token_ep <= ~ep;
  endtask
  task automatic sent(input logic [2:0] ep, input logic ack);
    @(posedge aclk);
    tx_done <= 1'b1;
    tx_ep <= ep;
    tx_acked <= ack;
    @(posedge aclk);
    tx_done <= 1'b0;
    tx_ep <= ~ep;
    tx_acked <= ~ack;
  endtask
endmodule

//--- verification/usb_in_endpoint_control_tb.sv
`timescale 1ns/10ps
module usb_in_endpoint_control_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, byte_loaded, in_token, tx_done;
  logic        awready, wready, bvalid, arready, rvalid, tx_acked, reply_toggle, t, t0, dsc, dsc_all;
  logic        fifo_discard, fifo_discard_all, ep0_write;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [2:0]  awprot, arprot, token_ep, tx_ep, load_ep, fifo_discard_ep, fifo_discard_all_ep, ep, e2;
  logic [1:0]  bresp, rresp, resp;
  logic [5:1]  ep_irq, irqs;
  logic [7:0]  ep0_status, ep0_wdata, ep0_got, d, v;
  int          mismatches, compares;
  uie_pkg::uie_reply_t reply, r;

  uie_in_ep_ctrl dut (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .in_token,
    .token_ep, .reply, .reply_toggle, .tx_done, .tx_ep, .tx_acked, .byte_loaded, .load_ep, .fifo_discard,
    .fifo_discard_ep, .fifo_discard_all, .fifo_discard_all_ep, .ep_irq, .ep0_status, .ep0_write, .ep0_wdata);
  uie_host_model host (.aclk, .reply, .reply_toggle, .in_token, .token_ep, .tx_done, .tx_ep, .tx_acked);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // pulses are caught at the falling edge, away from the launching edge
  always @(negedge aclk) begin
    irqs = irqs | ep_irq;
    dsc = dsc | (fifo_discard && fifo_discard_ep == ep);
    dsc_all = dsc_all | (fifo_discard_all && fifo_discard_all_ep == ep);
    if (ep0_write === 1'b1) ep0_got = ep0_wdata;
  end
  // ------
  // bus tasks and checks
  // ------
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wt(input int s);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while ((s == 0 ? awready : s == 1 ? bvalid : s == 2 ? arready : rvalid) !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("[FAIL] handshake expected answer seen none");
      stop_test();
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] dv);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, dv};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    wt(0);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    wt(1);
    resp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] idx, output logic [7:0] dv);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    wt(2);
    @(posedge aclk);
    arvalid <= 1'b0;
    wt(3);
    dv = rdata[7:0];
    resp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [15:0] idx, input logic [7:0] exp, input string name);
    logic [7:0] got;
    rd(idx, got);
    chk(name, exp, got);
  endtask
  task automatic load(input int n);
    @(posedge aclk);
    byte_loaded <= 1'b1;
    load_ep <= ep;
    repeat (n) @(posedge aclk);
    byte_loaded <= 1'b0;
  endtask
  // expected low register from packet count and flags
  function automatic logic [7:0] lo_val(input int cnt, cap, input logic und, snd, snt);
    return {2'b00, snt, snd, 1'b0, und, cnt != 0, cnt == cap};
  endfunction

  // one pass per endpoint; nb is a fresh-enough neighbour for the bank check
  task automatic run_pass(input logic [2:0] nb);
    wr(uie_pkg::IDX_EP_SELECT, {5'h0, ep});
    chk("select_bresp", uie_pkg::RESP_OKAY, resp);
    rc(uie_pkg::IDX_IN_CS_HI, 8'h20, "hi_reset");
    rc(uie_pkg::IDX_OUT_MAX, 8'h00, "out_max_reset");
    wr(uie_pkg::IDX_IN_CS_LO, 8'h01);
    rc(uie_pkg::IDX_IN_CS_LO, lo_val(1, 1, 0, 0, 0), "lo_loaded");
    host.tok(ep, r, t);
    chk("reply_data", uie_pkg::UIE_DATA, r);
    chk("toggle_first", 0, t);
    irqs = '0;
    host.sent(ep, 1'b1);
    rc(uie_pkg::IDX_IN_CS_LO, 8'h00, "lo_sent");
    chk("irq_sent", 1, irqs[ep]);
    host.tok(ep, r, t);
    chk("reply_nak", uie_pkg::UIE_NAK, r);
    chk("toggle_flip", 1, t);
    rc(uie_pkg::IDX_IN_CS_LO, lo_val(0, 1, 1, 0, 0), "lo_underrun");
    wr(uie_pkg::IDX_IN_CS_LO, 8'h40);
    host.tok(ep, r, t);
    chk("toggle_clear", 0, t);
    rc(uie_pkg::IDX_IN_CS_LO, lo_val(0, 1, 1, 0, 0), "lo_clear_self");
    wr(uie_pkg::IDX_IN_CS_LO, 8'h11);
    {irqs, dsc_all} = '0;
    repeat (2) begin
      host.tok(ep, r, t);
      chk("reply_stall", uie_pkg::UIE_STALL, r);
    end
    rc(uie_pkg::IDX_IN_CS_LO, lo_val(0, 1, 0, 1, 1), "lo_stalled");
    chk("stall_flush_irq", 2'b11, {dsc_all, irqs[ep]});
    wr(uie_pkg::IDX_IN_CS_HI, 8'h60);
    wr(uie_pkg::IDX_IN_CS_LO, 8'h10);
    host.tok(ep, r, t);
    chk("reply_iso", uie_pkg::UIE_ZLP, r);
    rc(uie_pkg::IDX_IN_CS_LO, lo_val(0, 1, 1, 1, 0), "lo_iso_under");
    wr(uie_pkg::IDX_IN_CS_HI, 8'h21);
    for (int i = 1; i <= 2; i++) begin
      wr(uie_pkg::IDX_IN_CS_LO, 8'h01);
      rc(uie_pkg::IDX_IN_CS_LO, lo_val(i, 2, 0, 0, 0), "lo_double");
    end
    for (int i = 1; i >= 0; i--) begin
      dsc = 1'b0;
      wr(uie_pkg::IDX_IN_CS_LO, 8'h08);
      rc(uie_pkg::IDX_IN_CS_LO, lo_val(i, 2, 0, 0, 0), "lo_flushed");
      chk("flush_pulse", 1, dsc);
    end
    wr(uie_pkg::IDX_IN_MAX, 8'h01);
    wr(uie_pkg::IDX_IN_CS_HI, 8'ha0);
    load(7);
    rc(uie_pkg::IDX_IN_CS_LO, 8'h00, "lo_auto_short");
    load(1);
    rc(uie_pkg::IDX_IN_CS_LO, lo_val(1, 1, 0, 0, 0), "lo_auto_full");
    wr(uie_pkg::IDX_IN_CS_HI, 8'h28);
    host.tok(ep, r, t0);
    dsc = 1'b0;
    host.sent(ep, 1'b0);
    rc(uie_pkg::IDX_IN_CS_LO, 8'h00, "lo_forced");
    host.tok(ep, r, t);
    chk("force_toggle", {~t0, 1'b1}, {t, dsc});
    // small sizes keep every endpoint within its share of the FIFO
    v = 8'(1 + $urandom % 8);
    wr(uie_pkg::IDX_OUT_MAX, v);
    wr(uie_pkg::IDX_EP_SELECT, {5'h0, nb});
    wr(uie_pkg::IDX_OUT_MAX, 8'(9 - v));
    wr(uie_pkg::IDX_EP_SELECT, {5'h0, ep});
    rc(uie_pkg::IDX_OUT_MAX, v, "out_max_bank");
    rd(16'hde0f, d);
    chk("unmapped_resp", uie_pkg::RESP_DECERR, resp);
    wr(16'hde0f, 8'h00);
    chk("unmapped_bresp", uie_pkg::RESP_DECERR, resp);
    wr(uie_pkg::IDX_EP_SELECT, 8'h00);
    ep0_status <= 8'($urandom);
    rd(uie_pkg::IDX_IN_CS_LO, d);
    chk("ep0_read", ep0_status, d);
    ep0_got = 8'h00;
    wr(uie_pkg::IDX_IN_CS_LO, v);
    chk("ep0_write", v, ep0_got);
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, byte_loaded, awaddr, araddr, wdata} = '0;
    {awprot, arprot, load_ep, ep0_status, irqs, dsc, dsc_all, ep0_got, mismatches, compares} = '0;
    wstrb = 4'h1;
    void'($urandom(50));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // endpoint 1 first, where the embedded checks look, then one other endpoint
    e2 = 3'(2 + $urandom % 4);
    for (int p = 0; p < 2; p++) begin
      ep = p == 0 ? 3'h1 : e2;
      run_pass(p == 0 ? 3'(e2 % 4 + 2) : 3'h1);
    end
    stop_test();
  end
endmodule
